// ---- ssc_pkg.sv ----
package ssc_pkg;
	localparam int          ADDR_W_DEF      = 17;
	localparam int          DATA_W_DEF      = 18;
	localparam int          FIFO_DEPTH_DEF  = 32;
	localparam int          BURST_W         = 2;
	localparam int          CLK_PERIOD_PS   = 10000;
	localparam int          CLOCK_PERIOD_NS = 10;
	localparam int          SLP_ENTRY_NS    = 2 * CLOCK_PERIOD_NS;
	localparam int          SLP_EXIT_NS     = 2 * CLOCK_PERIOD_NS;
	localparam int          SLP_ENTRY_CYC   = (SLP_ENTRY_NS * 1000) / CLK_PERIOD_PS;
	localparam int          SLP_EXIT_CYC    = (SLP_EXIT_NS * 1000) / CLK_PERIOD_PS;
	localparam logic        BURST_LINEAR    = 1'b0;
	localparam logic        RW_WRITE        = 1'b0;
	localparam logic [1:0]  BURST_CNT_RST   = 2'h0;

	typedef enum logic [1:0] {
		SSC_ACTIVE = 2'b01,
		SSC_SLEEP  = 2'b10
	} ssc_pwr_t;
endpackage

// ---- ssc_sram_ctrl.sv ----
`timescale 1ns/1ps

module ssc_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 32
) (
	input  logic         clk,
	input  logic         rst_n,
	input  logic         in_valid,
	output logic         in_ready,
	input  logic [W-1:0] in_data,
	output logic         out_valid,
	input  logic         out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} ssc_fifo_st_t;

	ssc_fifo_st_t st_ff;
	ssc_fifo_st_t nxt_st;
	logic [W-1:0] mem_ff [DEPTH];
	logic         push;
	logic         pop;

	assign in_ready  = !((st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]));
	assign out_valid = (st_ff.wp != st_ff.rp);
	assign out_data  = mem_ff[st_ff.rp[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wp = st_ff.wp + 1'b1;
		if (pop)
			nxt_st.rp = st_ff.rp + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
		if (push)
			mem_ff[st_ff.wp[AW-1:0]] <= in_data;
	end
endmodule

// Function
// - asynchronous high sleep request deselects memory
// - sleep lasts exactly while request held
// - sleeping ignores inputs, outputs go high-impedance
// - input sampling stops within two clocks
// - input sampling resumes within two clocks
// - pending operations may be lost entering sleep
// - burst order: zero linear, one interleaved
// - selected only for enables 0,0,1
// - reads forward pending write data coherently
// - held edge stalls pipeline, no write
// - cycle starts on load low, select picks op
module ssc_sram_ctrl
	import ssc_pkg::*;
#(
	parameter int ADDR_W     = ssc_pkg::ADDR_W_DEF,
	parameter int DATA_W     = ssc_pkg::DATA_W_DEF,
	parameter int FIFO_DEPTH = ssc_pkg::FIFO_DEPTH_DEF
) (
	input  logic              clk,
	input  logic              rst_n,
	input  logic              sleep_request,
	input  logic              select_low_a,
	input  logic              select_low_b,
	input  logic              select_high,
	input  logic              advance_load_n,
	input  logic              read_write_select,
	input  logic              cycle_hold_n,
	input  logic              burst_order_select,
	input  logic [ADDR_W-1:0] addr,
	input  logic [DATA_W-1:0] wr_data,
	output logic [DATA_W-1:0] rd_data,
	output logic              rd_valid,
	input  logic              rd_ready,
	output logic              rd_oe,
	output logic              asleep
);
	import ssc_pkg::*;

	localparam int ENT_CYC = SLP_ENTRY_CYC;

	if (ADDR_W <= BURST_W || DATA_W < 1) begin : g_bad_width
		$error("address or data width too small");
	end

	typedef struct packed {
		logic                sync1;
		ssc_pwr_t            pwr;
		logic                a_vld;
		logic                a_wr;
		logic [ADDR_W-1:0]   a_base;
		logic [BURST_W-1:0]  a_cnt;
		logic                pw_vld;
		logic [ADDR_W-1:0]   pw_addr;
		logic [DATA_W-1:0]   pw_data;
	} ssc_st_t;

	ssc_st_t           st_ff;
	ssc_st_t           nxt_st;
	logic [DATA_W-1:0] mem_ff [2**ADDR_W];
	logic              sleep_now;
	logic              selected;
	logic              en;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic              push;
	logic              mem_we;
	logic [ADDR_W-1:0] eff_addr;
	logic [BURST_W-1:0] low_bits;
	logic [DATA_W-1:0] fwd_data;

	assign sleep_now = (st_ff.pwr == SSC_SLEEP);
	assign asleep    = sleep_now;
	assign selected  = !select_low_a && !select_low_b && select_high;
	assign en        = !sleep_now && !cycle_hold_n && fifo_in_ready;

	always_comb begin
		if (burst_order_select == BURST_LINEAR)
			low_bits = st_ff.a_base[BURST_W-1:0] + st_ff.a_cnt;
		else
			low_bits = st_ff.a_base[BURST_W-1:0] ^ st_ff.a_cnt;
		eff_addr = {st_ff.a_base[ADDR_W-1:BURST_W], low_bits};
	end

	// newest data wins over the array
	assign fwd_data = (st_ff.pw_vld && st_ff.pw_addr == eff_addr) ?
		st_ff.pw_data : mem_ff[eff_addr];
	assign push   = en && st_ff.a_vld && !st_ff.a_wr;
	assign mem_we = en && st_ff.a_vld && st_ff.a_wr && st_ff.pw_vld;

	always_comb begin
		nxt_st       = st_ff;
		nxt_st.sync1 = sleep_request;
		nxt_st.pwr   = st_ff.sync1 ? SSC_SLEEP : SSC_ACTIVE;
		if (sleep_now) begin
			nxt_st.a_vld = 1'b0;
		end else if (en) begin
			if (!advance_load_n) begin
				nxt_st.a_vld  = selected;
				nxt_st.a_wr   = (read_write_select == RW_WRITE);
				nxt_st.a_base = addr;
				nxt_st.a_cnt  = BURST_CNT_RST;
			end else if (st_ff.a_vld) begin
				nxt_st.a_cnt = st_ff.a_cnt + 1'b1;
			end
			if (st_ff.a_vld && st_ff.a_wr) begin
				nxt_st.pw_vld  = 1'b1;
				nxt_st.pw_addr = eff_addr;
				nxt_st.pw_data = wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			st_ff <= '{pwr: SSC_ACTIVE, default: '0};
		else
			st_ff <= nxt_st;
		if (mem_we)
			mem_ff[st_ff.pw_addr] <= st_ff.pw_data;
	end

	ssc_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_ssc_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (fwd_data),
		.out_valid (fifo_out_valid),
		.out_ready (rd_ready && !sleep_now),
		.out_data  (rd_data)
	);

	assign rd_valid = fifo_out_valid && !sleep_now;
	assign rd_oe    = fifo_out_valid && !sleep_now;

	sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_request [*2] |=> sleep_now) else $error("sleep not entered in two clocks");
	sleep_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
		!sleep_request [*2] |=> !sleep_now) else $error("sleep not left in two clocks");
	sleep_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(sleep_request) |-> ##[1:ENT_CYC] (sleep_now || !sleep_request))
		else $error("sleep did not follow request");
	sleep_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_now |-> !rd_oe && !rd_valid && !mem_we && !push)
		else $error("activity while asleep");
	stall_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		cycle_hold_n |-> !mem_we && !push ##1 $stable(st_ff.pw_data))
		else $error("activity on held edge");
	deselect_a: assert property (@(posedge clk) disable iff (!rst_n)
		en && !advance_load_n && !selected |=> !st_ff.a_vld)
		else $error("started while deselected");
	start_op_a: assert property (@(posedge clk) disable iff (!rst_n)
		en && !advance_load_n && selected |=>
		st_ff.a_vld && st_ff.a_wr == !$past(read_write_select))
		else $error("cycle start lost or wrong type");
	burst_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		en && advance_load_n && st_ff.a_vld |=> st_ff.a_cnt == $past(st_ff.a_cnt) + 2'h1)
		else $error("burst counter did not advance");
	forward_a: assert property (@(posedge clk) disable iff (!rst_n)
		en && st_ff.a_vld && st_ff.a_wr ##1 push && eff_addr == st_ff.pw_addr |->
		fwd_data == st_ff.pw_data) else $error("read missed pending write");

	sleep_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
		sleep_now ##1 !sleep_now);
	fwd_read_c: cover property (@(posedge clk) disable iff (!rst_n)
		push && st_ff.pw_vld && eff_addr == st_ff.pw_addr);
	fifo_full_c: cover property (@(posedge clk) disable iff (!rst_n) !fifo_in_ready);
	stall_c: cover property (@(posedge clk) disable iff (!rst_n)
		st_ff.a_vld && cycle_hold_n);
	il_burst_c: cover property (@(posedge clk) disable iff (!rst_n)
		push && burst_order_select && st_ff.a_cnt == 2'h3);
endmodule

// ---- ssc_ctrl_model.sv ----
`timescale 1ns/1ps
module ssc_ctrl_model (
	input  wire logic        clk,
	output logic             select_low_a,
	output logic             select_low_b,
	output logic             select_high,
	output logic             advance_load_n,
	output logic             read_write_select,
	output logic [16:0]      addr,
	output logic [17:0]      wr_data
);
	logic [17:0] pend_d;
	logic        pend_v;
	initial begin
		{select_low_a, select_low_b, select_high} = 3'h0;
		advance_load_n = 1'b0;
		read_write_select = 1'b1;
		addr = 17'h0;
		wr_data = 18'h0;
		pend_v = 1'b0;
	end
	// one cycle start per call, write data one cycle later
	task automatic op(input logic [2:0] sel, input logic rw, input logic [16:0] a,
		input logic [17:0] d);
		@(negedge clk);
		{select_low_a, select_low_b, select_high} = sel;
		advance_load_n = 1'b0;
		read_write_select = rw;
		addr = a;
		wr_data = pend_v ? pend_d : ~wr_data;
		pend_v = !rw;
		pend_d = d;
	endtask
	// burst continue beat, keeps the op of the last start
	task automatic beat(input logic [17:0] d);
		@(negedge clk);
		advance_load_n = 1'b1;
		wr_data = pend_v ? pend_d : ~wr_data;
		pend_v = !read_write_select;
		pend_d = d;
	endtask
endmodule

// ---- sync_sram_sleep_and_cycle_control_test.sv ----
`timescale 1ns/1ps
module sync_sram_sleep_and_cycle_control_test;
	import ssc_pkg::*;
	logic        clk, rst_n, sleep_request, cycle_hold_n, burst_order_select, rd_ready;
	logic        select_low_a, select_low_b, select_high, advance_load_n, read_write_select;
	logic        rd_valid, rd_oe, asleep;
	logic [16:0] addr;
	logic [17:0] wr_data, rd_data;
	int          failures, checked;
	localparam logic [17:0] D = 18'h2A5A5;
	ssc_sram_ctrl u_ssc_sram_ctrl (.clk, .rst_n, .sleep_request, .select_low_a, .select_low_b,
		.select_high, .advance_load_n, .read_write_select, .cycle_hold_n, .burst_order_select,
		.addr, .wr_data, .rd_data, .rd_valid, .rd_ready, .rd_oe, .asleep);
	ssc_ctrl_model u_ssc_ctrl_model (.clk, .select_low_a, .select_low_b, .select_high,
		.advance_load_n, .read_write_select, .addr, .wr_data);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [2:0] sel);
		u_ssc_ctrl_model.op(sel, 1'b1, 17'h5, 18'h0);
		u_ssc_ctrl_model.op(3'h0, 1'b1, 17'h0, 18'h0);
	endtask
	task automatic none_out();
		repeat (4) @(negedge clk);
		check({17'h0, rd_valid}, 18'h1 ^ 18'h1);
	endtask
	task automatic pop(input logic [17:0] exp);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		check({17'h0, rd_oe}, 18'h1);
		check(rd_data, exp);
		rd_ready = 1'b1;
		@(negedge clk);
		rd_ready = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_fwd();
		u_ssc_ctrl_model.op(3'h1, 1'b0, 17'h5, D);
		rd(3'h1);
		pop(D);
	endtask
	task automatic burst_rd();
		u_ssc_ctrl_model.op(3'h1, 1'b1, 17'h9, 18'h0);
		repeat (3) u_ssc_ctrl_model.beat(18'h0);
		u_ssc_ctrl_model.op(3'h0, 1'b1, 17'h0, 18'h0);
	endtask
	task automatic t_burst();
		logic [17:0] d [4] = '{18'h00A01, 18'h00B02, 18'h00C03, 18'h00D04};
		u_ssc_ctrl_model.op(3'h1, 1'b0, 17'h8, d[0]);
		for (int i = 1; i < 4; i++) begin
			u_ssc_ctrl_model.beat(d[i]);
		end
		u_ssc_ctrl_model.op(3'h0, 1'b1, 17'h0, 18'h0);
		burst_order_select = 1'b1;
		burst_rd();
		pop(d[1]);
		pop(d[0]);
		pop(d[3]);
		pop(d[2]);
		burst_order_select = 1'b0;
		burst_rd();
		pop(d[1]);
		pop(d[2]);
		pop(d[3]);
		pop(d[0]);
		none_out();
	endtask
	task automatic t_desel();
		logic [2:0] bad [3] = '{3'h5, 3'h3, 3'h0};
		foreach (bad[i]) begin
			rd(bad[i]);
			none_out();
		end
	endtask
	task automatic t_stall();
		cycle_hold_n = 1'b1;
		rd(3'h1);
		cycle_hold_n = 1'b0;
		none_out();
	endtask
	task automatic t_sleep();
		rd(3'h1);
		repeat (4) @(negedge clk);
		sleep_request = 1'b1;
		repeat (2) @(negedge clk);
		check({16'h0, asleep, rd_oe}, 18'h2);
		rd(3'h1);
		none_out();
		sleep_request = 1'b0;
		repeat (2) @(negedge clk);
		check({17'h0, asleep}, 18'h0);
		pop(D);
		none_out();
	endtask
	task automatic t_fifo();
		int n;
		n = 0;
		repeat (40) u_ssc_ctrl_model.op(3'h1, 1'b1, 17'h5, 18'h0);
		u_ssc_ctrl_model.op(3'h0, 1'b1, 17'h0, 18'h0);
		rd_ready = 1'b1;
		repeat (60) begin
			if (rd_valid === 1'b1) begin
				n++;
				check(rd_data, D);
			end
			@(negedge clk);
		end
		rd_ready = 1'b0;
		check(18'(n), 18'(FIFO_DEPTH_DEF + 1));
	endtask
	initial begin
		failures = 0;
		checked = 0;
		rst_n = 1'b0;
		sleep_request = 1'b0;
		cycle_hold_n = 1'b0;
		burst_order_select = 1'b0;
		rd_ready = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_fwd();
		t_desel();
		t_stall();
		t_sleep();
		t_fifo();
		t_burst();
		finish_test();
	end
	initial begin
		#100us;
		failures++;
		finish_test();
	end
endmodule
